// *** logic/spf_port_status.sv ***
// Per-port status and control field bank with an indexed register port
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
module spf_port_status (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [spf_pkg::ADDR_W-1:0] i_addr,
    input wire logic [spf_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [spf_pkg::SEL_W-1:0] i_port_sel,
    input wire logic i_sleep_default_pin,
    input wire logic i_bus_reset,
    input wire logic [spf_pkg::NUM_PORTS-1:0][spf_pkg::SPD_W-1:0] i_port_capability,
    input wire logic [spf_pkg::NUM_PORTS-1:0] i_bilingual,
    input wire logic [spf_pkg::NUM_PORTS-1:0] i_beta_only,
    input wire logic [spf_pkg::NUM_PORTS-1:0] i_new_b_connection,
    input wire logic [spf_pkg::NUM_PORTS-1:0] i_speed_neg_fail,
    input wire logic [spf_pkg::NUM_PORTS-1:0] i_sync_fail,
    input wire logic [spf_pkg::NUM_PORTS-1:0] i_b_signaling,
    input wire logic [spf_pkg::NUM_PORTS-1:0] i_line_connected,
    input wire logic [spf_pkg::NUM_PORTS-1:0] i_line_rx_valid,
    input wire logic [spf_pkg::NUM_PORTS-1:0] i_invalid_codeword,
    input wire logic [spf_pkg::NUM_PORTS-1:0] i_sleep_request,
    input wire logic [spf_pkg::NUM_PORTS-1:0] i_standby,
    input wire logic [spf_pkg::NUM_PORTS-1:0] i_loop_disable_event,
    output logic [spf_pkg::DATA_W-1:0] o_rdata,
    output logic [spf_pkg::NUM_PORTS-1:0][spf_pkg::SPD_W-1:0] o_train_speed,
    output logic [spf_pkg::NUM_PORTS-1:0] o_connected,
    output logic [spf_pkg::NUM_PORTS-1:0] o_rx_valid,
    output logic [spf_pkg::NUM_PORTS-1:0] o_legacy_active,
    output logic [spf_pkg::NUM_PORTS-1:0] o_port_disabled,
    output logic [spf_pkg::NUM_PORTS-1:0] o_tone_enable,
    output logic [spf_pkg::NUM_PORTS-1:0] o_port_asleep
);
    localparam int N = spf_pkg::NUM_PORTS;
    localparam int SW = spf_pkg::SPD_W;

    // Stored per-port fields
    logic [N-1:0][SW-1:0] speed_limit;
    logic [N-1:0][spf_pkg::CNT_W-1:0] err_count;
    logic [N-1:0] unreliable;
    logic [N-1:0] b_status;
    logic [N-1:0] sleep_allow;
    logic [N-1:0] loop_blocked;
    logic [N-1:0] standby_status;
    logic [N-1:0] deep_off;
    logic [N-1:0] port_off;

    logic [N-1:0][SW-1:0] next_speed_limit;
    logic [N-1:0][SW-1:0] next_train_speed;
    logic [N-1:0][spf_pkg::CNT_W-1:0] next_err_count;
    logic [N-1:0] next_unreliable;
    logic [N-1:0] next_sleep_allow;
    logic [N-1:0] next_loop_blocked;
    logic [N-1:0] next_deep_off;
    logic [N-1:0] next_port_off;
    logic [N-1:0] next_connected;
    logic [N-1:0] next_rx_valid;
    logic [N-1:0] next_legacy_active;
    logic [N-1:0] next_b_status;
    logic [N-1:0] next_tone_enable;
    logic [N-1:0] next_asleep;
    logic [N-1:0] hard_off;
    logic [N-1:0] port_hit;

    // Decode
    wire sel_valid = (32'(i_port_sel) < N);
    wire hit_speed = (i_addr == spf_pkg::REG_SPEED);
    wire hit_link = (i_addr == spf_pkg::REG_LINK);
    wire hit_err = (i_addr == spf_pkg::REG_ERRCNT);
    wire hit_power = (i_addr == spf_pkg::REG_POWER);
    wire wr_speed = i_wr & hit_speed & sel_valid;
    wire wr_link = i_wr & hit_link & sel_valid;
    wire wr_power = i_wr & hit_power & sel_valid;
    wire rd_err = i_rd & hit_err & sel_valid;
    wire [SW-1:0] wr_limit = i_wdata[spf_pkg::SPEED_LIMIT_LSB +: SW];
    wire wr_unrel_clear = i_wdata[spf_pkg::LINK_UNREL_BIT];

    // Out-of-range selects read the first port's copy but return zero
    wire [spf_pkg::SEL_W-1:0] sel = sel_valid ? i_port_sel : '0;

    genvar p;
    generate
        for (p = 0; p < N; p = p + 1) begin : g_port
            // Per-port strobes and event terms
            wire [SW-1:0] cap = i_port_capability[p];
            wire con_raw = i_line_connected[p];
            wire rx_raw = i_line_rx_valid[p];
            wire write_p_speed = wr_speed & port_hit[p];
            wire write_p_link = wr_link & port_hit[p];
            wire write_p_power = wr_power & port_hit[p];
            wire read_p_err = rd_err & port_hit[p];
            wire link_fail = i_speed_neg_fail[p] | i_sync_fail[p];
            wire unrel_clear = write_p_link & wr_unrel_clear;
            wire limit_write = write_p_speed & ~i_bilingual[p];
            wire train_load = i_new_b_connection[p] & i_beta_only[p];
            wire cnt_full = (err_count[p] == spf_pkg::CNT_MAX);
            wire [spf_pkg::CNT_W-1:0] cnt_inc = err_count[p] + spf_pkg::CNT_ONE;
            wire loop_clear = i_bus_reset | ~con_raw;
            // Reserved codes exceed every capability, so they clamp too
            wire [SW-1:0] clamped = (wr_limit > cap) ? cap : wr_limit;

            assign port_hit[p] = (32'(i_port_sel) == p);

            // Reset value follows the port capability, so it is loaded each reset cycle
            assign next_speed_limit[p] = !i_rst_b ? cap :
                limit_write ? clamped :
                speed_limit[p];

            // Bilingual ports never train at the programmed limit
            assign next_train_speed[p] = i_bilingual[p] ? spf_pkg::SPD_S400 :
                train_load ? speed_limit[p] :
                o_train_speed[p];

            // Failure in the clearing cycle keeps the flag set
            assign next_unreliable[p] = link_fail ? 1'b1 :
                unrel_clear ? 1'b0 :
                unreliable[p];

            // A code word arriving with the clearing read counts as the first one
            assign next_err_count[p] = i_invalid_codeword[p] ?
                (read_p_err ? spf_pkg::CNT_ONE :
                 cnt_full ? err_count[p] :
                 cnt_inc) :
                read_p_err ? spf_pkg::CNT_ZERO :
                err_count[p];

            assign next_sleep_allow[p] = !i_rst_b ? i_sleep_default_pin :
                write_p_power ? i_wdata[spf_pkg::PWR_ALLOW_BIT] :
                sleep_allow[p];

            assign next_asleep[p] = i_sleep_request[p] & sleep_allow[p];

            // Build event wins over a simultaneous bus reset
            assign next_loop_blocked[p] = i_loop_disable_event[p] ? 1'b1 :
                loop_clear ? 1'b0 :
                loop_blocked[p];

            assign next_deep_off[p] = write_p_power ?
                i_wdata[spf_pkg::PWR_DEEP_BIT] : deep_off[p];
            // Bus reset deliberately not a term here
            assign next_port_off[p] = write_p_power ?
                i_wdata[spf_pkg::PWR_OFF_BIT] : port_off[p];

            // Deep off only bites on a disabled port
            assign hard_off[p] = port_off[p] & deep_off[p];
            assign next_connected[p] = con_raw & ~hard_off[p];
            assign next_rx_valid[p] = rx_raw & ~hard_off[p];
            // Disconnected port never reports b signaling
            assign next_b_status[p] = i_b_signaling[p] & con_raw;
            assign next_legacy_active[p] = next_connected[p] & next_rx_valid[p] &
                ~next_b_status[p] & ~port_off[p];
            // Silence also forces speed renegotiation on re-enable
            assign next_tone_enable[p] = ~hard_off[p];
        end
    endgenerate

    // Selected port's copy of every field
    wire [SW-1:0] sel_limit = speed_limit[sel];
    wire [SW-1:0] sel_cap = i_port_capability[sel];
    wire [spf_pkg::CNT_W-1:0] sel_count = err_count[sel];
    wire sel_unrel = unreliable[sel];
    wire sel_bsig = b_status[sel];
    wire sel_asleep = o_port_asleep[sel];
    wire sel_allow = sleep_allow[sel];
    wire sel_loop = loop_blocked[sel];
    wire sel_standby = standby_status[sel];
    wire sel_deep = deep_off[sel];
    wire sel_off = port_off[sel];

    // Read words assembled at the field positions
    wire [spf_pkg::DATA_W-1:0] rd_speed =
        ({5'h00, sel_limit} << spf_pkg::SPEED_LIMIT_LSB) |
        ({7'h00, spf_pkg::LOCAL_PLUG_VALUE} << spf_pkg::SPEED_PLUG_BIT) |
        ({5'h00, sel_cap} << spf_pkg::SPEED_CAP_LSB);
    wire [spf_pkg::DATA_W-1:0] rd_link =
        ({7'h00, sel_unrel} << spf_pkg::LINK_UNREL_BIT) |
        ({7'h00, sel_bsig} << spf_pkg::LINK_BSIG_BIT);
    wire [spf_pkg::DATA_W-1:0] rd_power =
        ({7'h00, sel_asleep} << spf_pkg::PWR_ASLEEP_BIT) |
        ({7'h00, sel_allow} << spf_pkg::PWR_ALLOW_BIT) |
        ({7'h00, sel_loop} << spf_pkg::PWR_LOOP_BIT) |
        ({7'h00, sel_standby} << spf_pkg::PWR_STANDBY_BIT) |
        ({7'h00, sel_deep} << spf_pkg::PWR_DEEP_BIT) |
        ({7'h00, sel_off} << spf_pkg::PWR_OFF_BIT);
    wire [spf_pkg::DATA_W-1:0] rd_word =
        !sel_valid ? spf_pkg::RDATA_IDLE :
        hit_speed ? rd_speed :
        hit_link ? rd_link :
        hit_err ? sel_count :
        hit_power ? rd_power :
        spf_pkg::RDATA_IDLE;
    wire [spf_pkg::DATA_W-1:0] next_rdata = i_rd ? rd_word : spf_pkg::RDATA_IDLE;

    // Fields whose reset value comes from an input
    always_ff @(posedge i_clock) begin
        speed_limit <= next_speed_limit;
    end

    always_ff @(posedge i_clock) begin
        sleep_allow <= next_sleep_allow;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            unreliable <= '0;
        end else begin
            unreliable <= next_unreliable;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            err_count <= '0;
        end else begin
            err_count <= next_err_count;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            loop_blocked <= '0;
        end else begin
            loop_blocked <= next_loop_blocked;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            deep_off <= '0;
        end else begin
            deep_off <= next_deep_off;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            port_off <= '0;
        end else begin
            port_off <= next_port_off;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            b_status <= '0;
        end else begin
            b_status <= next_b_status;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            standby_status <= '0;
        end else begin
            standby_status <= i_standby;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_port_asleep <= '0;
        end else begin
            o_port_asleep <= next_asleep;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_train_speed <= '0;
        end else begin
            o_train_speed <= next_train_speed;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_rdata <= spf_pkg::RDATA_IDLE;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    // Status outputs registered so they come straight from flip-flops
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_connected <= '0;
        end else begin
            o_connected <= next_connected;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_rx_valid <= '0;
        end else begin
            o_rx_valid <= next_rx_valid;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_legacy_active <= '0;
        end else begin
            o_legacy_active <= next_legacy_active;
        end
    end

    // Copies the stored control so it lines up with the forced line flags
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_port_disabled <= '0;
        end else begin
            o_port_disabled <= port_off;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_tone_enable <= '1;
        end else begin
            o_tone_enable <= next_tone_enable;
        end
    end
endmodule : spf_port_status

// *** logic/spf_pkg.sv ***
// Constants, field layout and register map of the port status bank
package spf_pkg;
    localparam int NUM_PORTS = 3;
    localparam int SEL_W = 2;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int SPD_W = 3;
    localparam int CNT_W = 8;

    localparam logic [SPD_W-1:0] SPD_S100 = 3'h0;
    localparam logic [SPD_W-1:0] SPD_S200 = 3'h1;
    localparam logic [SPD_W-1:0] SPD_S400 = 3'h2;
    localparam logic [SPD_W-1:0] SPD_S800 = 3'h3;
    localparam logic [SPD_W-1:0] SPD_S1600 = 3'h4;
    localparam logic [SPD_W-1:0] SPD_S3200 = 3'h5;

    localparam logic [ADDR_W-1:0] REG_SPEED = 4'h8;
    localparam logic [ADDR_W-1:0] REG_LINK = 4'h9;
    localparam logic [ADDR_W-1:0] REG_ERRCNT = 4'hA;
    localparam logic [ADDR_W-1:0] REG_POWER = 4'hB;

    localparam int SPEED_LIMIT_LSB = 5;
    localparam int SPEED_PLUG_BIT = 4;
    localparam int SPEED_CAP_LSB = 1;
    localparam int LINK_UNREL_BIT = 7;
    localparam int LINK_BSIG_BIT = 6;
    localparam int PWR_ASLEEP_BIT = 7;
    localparam int PWR_ALLOW_BIT = 6;
    localparam int PWR_LOOP_BIT = 5;
    localparam int PWR_STANDBY_BIT = 4;
    localparam int PWR_DEEP_BIT = 3;
    localparam int PWR_OFF_BIT = 2;

    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;
    localparam logic LOCAL_PLUG_VALUE = 1'b1;
endpackage : spf_pkg

// *** test/spf_link_model.sv ***
// Link-layer controller model driving the indexed register port
`timescale 1ns/1ps
module spf_link_model (
    input wire logic i_clock,
    input wire logic [7:0] i_rdata,
    output logic [3:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    output logic [1:0] o_sel
);
    initial begin
        o_addr = 4'h0;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_sel = 2'h0;
    end
    // Leading edge keeps strobes of back-to-back calls apart
    task automatic wr(input logic [1:0] s, input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        o_sel <= s;
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clock);
        o_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] s, input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clock);
        o_sel <= s;
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clock);
        o_rd <= 1'b0;
        @(posedge i_clock);
        d = i_rdata;
    endtask : rd
endmodule : spf_link_model

// *** test/spf_port_status_sva.sv ***
// Assertions on the register port and the per-port pins
`timescale 1ns/1ps
module spf_port_status_sva (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [3:0] i_addr,
    input wire logic i_rd,
    input wire logic [1:0] i_port_sel,
    input wire logic [2:0][2:0] i_port_capability,
    input wire logic [2:0] i_bilingual,
    input wire logic [2:0] i_line_connected,
    input wire logic [2:0] i_line_rx_valid,
    input wire logic [2:0] i_b_signaling,
    input wire logic [2:0] i_sleep_request,
    input wire logic [7:0] o_rdata,
    input wire logic [2:0][2:0] o_train_speed,
    input wire logic [2:0] o_connected,
    input wire logic [2:0] o_rx_valid,
    input wire logic [2:0] o_legacy_active,
    input wire logic [2:0] o_port_disabled,
    input wire logic [2:0] o_tone_enable,
    input wire logic [2:0] o_port_asleep
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    sequence s_spd_rd;
        i_rd && i_addr == spf_pkg::REG_SPEED && i_port_sel != 2'h3;
    endsequence
    a_plug_one: assert property (s_spd_rd |=> o_rdata[4])
        else $error("plug bit low");
    a_cap_field: assert property (s_spd_rd |=> o_rdata[3:1] == $past(i_port_capability[i_port_sel]))
        else $error("capability field wrong");
    a_bad_sel: assert property (i_rd && i_port_sel == 2'h3 |=> o_rdata == 8'h00)
        else $error("invalid select read not zero");
    a_bil_speed: assert property (i_rst_b && i_bilingual[1] |=> o_train_speed[1] == spf_pkg::SPD_S400)
        else $error("bilingual speed not fixed");
    a_deep_forces: assert property (!o_tone_enable[1] |-> !o_connected[1] && !o_rx_valid[1])
        else $error("deep off did not force flags");
    a_tone_off_cause: assert property (!o_tone_enable[1] |-> o_port_disabled[1])
        else $error("tones stopped on enabled port");
    a_off_inactive: assert property (o_port_disabled[1] |-> !o_legacy_active[1])
        else $error("disabled port active");
    a_legacy_cause: assert property (o_legacy_active[0] |-> $past(i_line_connected[0] && i_line_rx_valid[0] && !i_b_signaling[0]))
        else $error("legacy active without cause");
    a_asleep_cause: assert property (o_port_asleep[1] |-> $past(i_sleep_request[1]))
        else $error("asleep without request");
    a_conn_follows: assert property ($past(i_rst_b) && !o_port_disabled[0] |-> o_connected[0] == $past(i_line_connected[0]))
        else $error("connect flag altered on enabled port");
endmodule : spf_port_status_sva
bind spf_port_status spf_port_status_sva u_sva (.i_clock, .i_rst_b, .i_addr, .i_rd, .i_port_sel,
    .i_port_capability, .i_bilingual, .i_line_connected, .i_line_rx_valid, .i_b_signaling,
    .i_sleep_request, .o_rdata, .o_train_speed, .o_connected, .o_rx_valid, .o_legacy_active,
    .o_port_disabled, .o_tone_enable, .o_port_asleep);

// *** test/tb_top.sv ***
// Self-checking bench for the port status bank
`timescale 1ns/1ps
module tb_top;
    logic i_clock = 1'b0, i_rst_b = 1'b0, i_sleep_default_pin = 1'b1, i_bus_reset = 1'b0;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, rdata;
    logic i_wr, i_rd;
    logic [1:0] i_port_sel;
    logic [2:0][2:0] i_port_capability = {3'h3, 3'h2, 3'h5}, o_train_speed;
    logic [2:0] i_bilingual = 3'h2, i_beta_only = 3'h4, i_line_connected = 3'h7;
    logic [2:0] i_new_b_connection = 3'h0, i_speed_neg_fail = 3'h0, i_sync_fail = 3'h0;
    logic [2:0] i_b_signaling = 3'h0, i_line_rx_valid = 3'h7, i_invalid_codeword = 3'h0;
    logic [2:0] i_sleep_request = 3'h0, i_standby = 3'h0, i_loop_disable_event = 3'h0;
    logic [2:0] o_connected, o_rx_valid, o_legacy_active, o_port_disabled, o_tone_enable;
    logic [2:0] o_port_asleep;
    int failures = 0, checked = 0, cycles = 0, n;
    integer seed = 32'h5db3;
    spf_port_status u_dut (.*);
    spf_link_model u_link (.i_clock, .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
        .o_wr(i_wr), .o_rd(i_rd), .o_sel(i_port_sel));
    initial begin
        forever #10 i_clock = ~i_clock;
    end
    function automatic logic [2:0] exp_lim(int p, logic [2:0] c);
        if (i_bilingual[p]) return spf_pkg::SPD_S400;
        return (c > i_port_capability[p]) ? i_port_capability[p] : c;
    endfunction : exp_lim
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic chk(input logic [1:0] s, input logic [3:0] a, input logic [7:0] m,
        input logic [7:0] e, input string nm);
        u_link.rd(s, a, rdata);
        cmp(nm, e, rdata & m);
    endtask : chk
    localparam int EV_NEWB = 0, EV_SYNC = 1, EV_NEG = 2, EV_CODE = 3, EV_LOOP = 4;
    // One-cycle pulse on the chosen event input, second pass drops it
    task automatic pulse(input int k, input logic [2:0] m);
        repeat (2) begin
            @(posedge i_clock);
            case (k)
                EV_NEWB: i_new_b_connection <= m;
                EV_SYNC: i_sync_fail <= m;
                EV_NEG: i_speed_neg_fail <= m;
                EV_CODE: i_invalid_codeword <= m;
                default: i_loop_disable_event <= m;
            endcase
            m = 3'h0;
        end
        @(negedge i_clock);
    endtask : pulse
    task automatic give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    // Ceiling well above the roughly 800 cycles the sequence needs
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge i_clock);
        i_rst_b <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            chk(p[1:0], 4'h8, 8'hFF, {i_port_capability[p], 1'b1, i_port_capability[p], 1'b0}, "speed");
            chk(p[1:0], 4'hB, 8'h40, 8'h40, "allow");
        end
        for (int c = 0; c < 8; c++) begin
            for (int p = 0; p < 3; p++) begin
                u_link.wr(p[1:0], 4'h8, {c[2:0], 5'($random(seed))});
                chk(p[1:0], 4'h8, 8'hE0, {exp_lim(p, c[2:0]), 5'h00}, "limit");
            end
        end
        u_link.wr(2'h2, 4'h8, 8'h20);
        pulse(EV_NEWB, 3'h5);
        cmp("train2", 8'h01, 8'(o_train_speed[2]));
        cmp("train0", 8'h00, 8'(o_train_speed[0]));
        pulse(EV_SYNC, 3'h1);
        chk(2'h0, 4'h9, 8'h80, 8'h80, "unrel");
        u_link.wr(2'h0, 4'h9, 8'h00);
        chk(2'h0, 4'h9, 8'h80, 8'h80, "unrel");
        u_link.wr(2'h0, 4'h9, 8'h80);
        chk(2'h0, 4'h9, 8'h80, 8'h00, "unrel");
        pulse(EV_NEG, 3'h4);
        chk(2'h2, 4'h9, 8'h80, 8'h80, "unrel");
        @(posedge i_clock) i_b_signaling <= 3'h4;
        chk(2'h2, 4'h9, 8'h40, 8'h40, "bsig");
        cmp("legacy", 8'h03, 8'(o_legacy_active));
        @(posedge i_clock) i_line_connected <= 3'h3;
        chk(2'h2, 4'h9, 8'h40, 8'h00, "bsig");
        n = 1 + ($random(seed) & 15);
        repeat (n) pulse(EV_CODE, 3'h2);
        chk(2'h1, 4'hA, 8'hFF, n[7:0], "errcnt");
        chk(2'h1, 4'hA, 8'hFF, 8'h00, "errcnt");
        repeat (260) pulse(EV_CODE, 3'h1);
        chk(2'h0, 4'hA, 8'hFF, 8'hFF, "errcnt");
        chk(2'h2, 4'hA, 8'hFF, 8'h00, "errcnt");
        chk(2'h0, 4'h3, 8'hFF, 8'h00, "unmapped");
        chk(2'h3, 4'h8, 8'hFF, 8'h00, "badsel");
        u_link.wr(2'h0, 4'hB, 8'h00);
        @(posedge i_clock) i_sleep_request <= 3'h7;
        chk(2'h0, 4'hB, 8'hC0, 8'h00, "sleep");
        chk(2'h1, 4'hB, 8'hC0, 8'hC0, "sleep");
        cmp("asleep", 8'h06, 8'(o_port_asleep));
        @(posedge i_clock) i_line_connected <= 3'h7;
        pulse(EV_LOOP, 3'h3);
        chk(2'h0, 4'hB, 8'h20, 8'h20, "loop");
        @(posedge i_clock) i_bus_reset <= 1'b1;
        @(posedge i_clock) i_bus_reset <= 1'b0;
        chk(2'h0, 4'hB, 8'h20, 8'h00, "loop");
        pulse(EV_LOOP, 3'h2);
        @(posedge i_clock) i_line_connected <= 3'h5;
        chk(2'h1, 4'hB, 8'h20, 8'h00, "loop");
        @(posedge i_clock) i_line_connected <= 3'h7;
        @(posedge i_clock) i_standby <= 3'h1;
        chk(2'h0, 4'hB, 8'h10, 8'h10, "standby");
        chk(2'h1, 4'hB, 8'h10, 8'h00, "standby");
        u_link.wr(2'h1, 4'hB, 8'h08);
        repeat (2) @(negedge i_clock);
        cmp("conn", 8'h07, 8'(o_connected));
        u_link.wr(2'h1, 4'hB, 8'h0C);
        repeat (2) @(negedge i_clock);
        cmp("conn", 8'h05, 8'(o_connected));
        cmp("rxv", 8'h05, 8'(o_rx_valid));
        cmp("tone", 8'h05, 8'(o_tone_enable));
        cmp("disabled", 8'h02, 8'(o_port_disabled));
        @(posedge i_clock) i_bus_reset <= 1'b1;
        @(posedge i_clock) i_bus_reset <= 1'b0;
        chk(2'h1, 4'hB, 8'h0C, 8'h0C, "off");
        i_sleep_default_pin <= 1'b0;
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_rst_b <= 1'b1;
        chk(2'h1, 4'hB, 8'h4C, 8'h00, "off");
        give_verdict();
    end
endmodule : tb_top
